/* File: src/urc_rx_ctl.sv */
// usb receiver enable, receive mode and packet receive status registers
// assumes an 8-bit cpu bus with byte and single-bit writes, packet
// events from the neighbouring receiver on clk, raw bus lines on pins
//
// How it works
// RL1: enable bit zero halts receiver, others zero
// RL2: reset, resume, idle eop always detected
// RL3: write mask blocks buffer writes above 11h
// RL4: sync enable gates receive status interrupt
// RL5: reset needs 3.0 us se0 or edge
// RL6: software sets edge mode only in suspend
// RL7: software rereads reset flag to confirm
// RL8: setup reception clears receive mode register
// RL9: packet flags set on pid, cleared on eop
// RL10: bus flags sticky, software clears, never sets
// RL11: usb clock past 85.3 us stops, flags
// RL12: reset or resume also sets runaway flag
// RL13: software clears runaway flag, never sets it
// RL14: reset gives se0+reset, resume gives resume+runaway
// RL15: status byte layout runaway down to token
// RL16: status byte access only, others bitwise too
// RL17: all three registers reset to zero
// RL18: setup token clears write mask and reservations
// RL19: receiver off stops packet flags setting, eop still clears
`timescale 1ns/100ps
module urc_rx_ctl
   import urc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_bit_wr,
   input  wire logic [2:0]  cpu_bit_sel,
   input  wire logic        cpu_bit_val,
   input  wire logic        cpu_rd,
   output logic      [7:0]  cpu_rdata,
   input  wire logic        usb_dp,
   input  wire logic        usb_dm,
   input  wire logic        token_pid_hit,
   input  wire logic        data_pid_hit,
   input  wire logic        handshake_pid_hit,
   input  wire logic        packet_eop,
   input  wire logic        setup_token_seen,
   input  wire logic        setup_reception,
   input  wire logic        usb_clk_running,
   input  wire logic        data_handshake_rx_irq,
   input  wire logic [7:0]  buf_wr_addr,
   output logic             buf_wr_allow,
   output logic             receiver_on,
   output logic             rx_buffer_write_mask,
   output logic             sync_status_irq_enable,
   output logic             reset_detect_edge_mode,
   output logic             sync_status_irq,
   output logic             usb_clk_stop,
   output logic             clear_tx_reservations,
   output logic             clear_data_nak_enable
);

   // ======================================================
   // declarations
   logic [7:0]                 enable_reg;
   logic [7:0]                 mode_reg;
   logic [URC_PKT_FLAGS-1:0]   pkt_flags;
   logic [URC_BUS_FLAGS-1:0]   bus_flags;
   logic [URC_PKT_FLAGS-1:0]   pkt_set;
   logic [URC_PKT_FLAGS-1:0]   pkt_clear;
   logic [URC_BUS_FLAGS-1:0]   bus_set;
   logic [URC_BUS_FLAGS-1:0]   bus_clear;
   logic [7:0]                 status_byte;
   logic                       dp_meta;
   logic                       dp_sync;
   logic                       dm_meta;
   logic                       dm_sync;
   urc_line_type               line_now;
   urc_line_type               line_prev;
   logic [5:0]                 se0_cnt;
   logic [9:0]                 run_cnt;
   logic                       line_is_se0;
   logic                       se0_enter;
   logic                       eop_evt;
   logic                       resume_evt;
   logic                       j_to_se0;
   logic                       reset_level_evt;
   logic                       reset_evt;
   logic                       timer_expire;
   logic                       runaway_set;
   logic                       wr_enable;
   logic                       wr_mode;
   logic                       wr_status;
   logic                       bit_enable;
   logic                       bit_mode;
   logic [7:0]                 next_enable;
   logic [7:0]                 next_mode;

   // ======================================================
   // cpu write decode
   always_comb begin
      wr_enable  = 1'b0;
      wr_mode    = 1'b0;
      wr_status  = 1'b0;
      bit_enable = 1'b0;
      bit_mode   = 1'b0;
      if (cpu_addr == URC_RX_ENABLE_ADDR) begin
         wr_enable  = cpu_wr;
         bit_enable = cpu_bit_wr;
      end else if (cpu_addr == URC_RX_MODE_ADDR) begin
         wr_mode  = cpu_wr;
         bit_mode = cpu_bit_wr;
      end else if (cpu_addr == URC_RX_STATUS_ADDR) begin
         // bit writes to the status byte are dropped
         wr_status = cpu_wr; // RL16
      end
   end

   // ======================================================
   // receiver enable register
   always_comb begin
      next_enable = enable_reg;
      if (wr_enable) begin
         next_enable = cpu_wdata & URC_ENABLE_BITS; // RL1
      end else if (bit_enable) begin
         next_enable[cpu_bit_sel] = cpu_bit_val; // RL16
         next_enable = next_enable & URC_ENABLE_BITS; // RL1
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_reg <= URC_REG_RESET; // RL17
      end else begin
         enable_reg <= next_enable;
      end
   end

   assign receiver_on = enable_reg[URC_RXON_BIT];

   // ======================================================
   // receive mode register
   always_comb begin
      next_mode = mode_reg;
      if (wr_mode) begin
         next_mode = cpu_wdata & URC_MODE_BITS;
      end else if (bit_mode) begin
         next_mode[cpu_bit_sel] = cpu_bit_val; // RL16
         next_mode = next_mode & URC_MODE_BITS;
      end
      // hardware clears beat a software write in the same cycle
      if (setup_reception) begin
         next_mode = URC_REG_RESET; // RL8
      end else if (setup_token_seen) begin
         next_mode[URC_WMASK_BIT] = 1'b0; // RL18
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= URC_REG_RESET; // RL17
      end else begin
         mode_reg <= next_mode;
      end
   end

   assign rx_buffer_write_mask   = mode_reg[URC_WMASK_BIT];
   assign sync_status_irq_enable = mode_reg[URC_SYNC_IRQ_BIT];
   assign reset_detect_edge_mode = mode_reg[URC_EDGE_MODE_BIT];

   // the edge mode is only safe in suspend; idle traffic would trip it
   // RL6 RL7

   // ======================================================
   // buffer write guard and synchronous interrupt
   always_comb begin
      buf_wr_allow = 1'b1;
      if (rx_buffer_write_mask && (buf_wr_addr > URC_MASK_LIMIT)) begin
         buf_wr_allow = 1'b0; // RL3
      end
   end

   // combinational so it rides in the same cycle as the receive irq
   assign sync_status_irq = data_handshake_rx_irq
                            & sync_status_irq_enable; // RL4

   // ======================================================
   // setup token side effects on neighbouring registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clear_tx_reservations <= 1'b0;
         clear_data_nak_enable <= 1'b0;
      end else begin
         clear_tx_reservations <= setup_token_seen; // RL18
         clear_data_nak_enable <= setup_token_seen; // RL18
      end
   end

   // ======================================================
   // line synchroniser and state tracking
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // reset to idle j so release does not fake an se0 entry
         dp_meta <= 1'b1;
         dp_sync <= 1'b1;
         dm_meta <= 1'b0;
         dm_sync <= 1'b0;
      end else begin
         dp_meta <= usb_dp;
         dp_sync <= dp_meta;
         dm_meta <= usb_dm;
         dm_sync <= dm_meta;
      end
   end

   always_comb begin
      case ({dp_sync, dm_sync})
         2'b10:   line_now = URC_LINE_J;
         2'b01:   line_now = URC_LINE_K;
         2'b00:   line_now = URC_LINE_SE0;
         default: line_now = URC_LINE_SE1;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_prev <= URC_LINE_J;
      end else begin
         line_prev <= line_now;
      end
   end

   // ======================================================
   // bus transition events, never gated by the receiver enable
   assign line_is_se0 = (line_now == URC_LINE_SE0);
   assign se0_enter   = line_is_se0 && (line_prev != URC_LINE_SE0); // RL2
   assign eop_evt     = (line_prev == URC_LINE_SE0)
                        && (line_now == URC_LINE_J); // RL2
   assign resume_evt  = (line_prev == URC_LINE_J)
                        && (line_now == URC_LINE_K); // RL2
   assign j_to_se0    = (line_prev == URC_LINE_J) && line_is_se0;

   // counts se0 cycles, saturating, so one reset per se0 period
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         se0_cnt <= '0;
      end else if (!line_is_se0) begin
         se0_cnt <= '0;
      end else if (se0_cnt != URC_RESET_MIN_CYC) begin
         se0_cnt <= se0_cnt + 6'h01;
      end
   end

   assign reset_level_evt = line_is_se0
                            && (se0_cnt == URC_RESET_MIN_CYC - 6'h01);
   assign reset_evt = reset_detect_edge_mode ? j_to_se0
                                             : reset_level_evt; // RL5

   // ======================================================
   // usb clock runaway timer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         run_cnt <= '0;
      end else if (!usb_clk_running) begin
         run_cnt <= '0;
      end else if (run_cnt != URC_RUNAWAY_CYC) begin
         run_cnt <= run_cnt + 10'h001;
      end
   end

   assign timer_expire = usb_clk_running
                         && (run_cnt == URC_RUNAWAY_CYC - 10'h001); // RL11

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         usb_clk_stop <= 1'b0;
      end else begin
         usb_clk_stop <= timer_expire; // RL11
      end
   end

   assign runaway_set = timer_expire | reset_evt | resume_evt; // RL12

   // ======================================================
   // status flags
   always_comb begin
      pkt_set   = '0;
      pkt_clear = '0;
      if (receiver_on) begin
         pkt_set = {handshake_pid_hit, data_pid_hit, token_pid_hit}; // RL19
      end
      if (packet_eop || eop_evt) begin
         pkt_clear = '1; // RL9
      end
   end

   // reset raises se0 too, resume raises its own flag and runaway
   assign bus_set = {runaway_set, resume_evt, se0_enter, reset_evt,
                     eop_evt}; // RL14
   // writing zero clears; writing one leaves a flag alone
   assign bus_clear = wr_status ? ~cpu_wdata[URC_RUNAWAY_BIT:URC_EOP_BIT]
                                : '0; // RL10 RL13

   urc_sticky #(
      .WIDTH (URC_PKT_FLAGS)
   ) u_pkt_flags (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (pkt_set),
      .clear   (pkt_clear),
      .flag    (pkt_flags)
   ); // RL9

   urc_sticky #(
      .WIDTH (URC_BUS_FLAGS)
   ) u_bus_flags (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (bus_set),
      .clear   (bus_clear),
      .flag    (bus_flags)
   ); // RL10

   assign status_byte = {bus_flags, pkt_flags}; // RL15

   // ======================================================
   // read port, answered one cycle after the request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_rdata <= URC_REG_RESET;
      end else if (!cpu_rd) begin
         cpu_rdata <= URC_REG_RESET;
      end else if (cpu_addr == URC_RX_ENABLE_ADDR) begin
         cpu_rdata <= enable_reg;
      end else if (cpu_addr == URC_RX_MODE_ADDR) begin
         cpu_rdata <= mode_reg;
      end else if (cpu_addr == URC_RX_STATUS_ADDR) begin
         cpu_rdata <= status_byte;
      end else begin
         cpu_rdata <= URC_REG_RESET;
      end
   end

   // ======================================================
   // checks
   mask_guard_a: assert property ( // RL3
      @(posedge clk) disable iff (!reset_n)
      (rx_buffer_write_mask && buf_wr_addr > URC_MASK_LIMIT)
         |-> !buf_wr_allow)
      else $error("masked buffer write was allowed");

   sync_irq_a: assert property ( // RL4
      @(posedge clk) disable iff (!reset_n)
      (data_handshake_rx_irq && !mode_reg[URC_SYNC_IRQ_BIT])
         |-> !sync_status_irq)
      else $error("sync interrupt raised while disabled");

   setup_clear_a: assert property ( // RL8
      @(posedge clk) disable iff (!reset_n)
      setup_reception |=> (mode_reg == URC_REG_RESET))
      else $error("setup reception left receive mode set");

   setup_mask_a: assert property ( // RL18
      @(posedge clk) disable iff (!reset_n)
      setup_token_seen |=> (!rx_buffer_write_mask
                            && clear_tx_reservations
                            && clear_data_nak_enable))
      else $error("setup token did not clear mask and reservations");

   level_reset_a: assert property ( // RL5
      @(posedge clk) disable iff (!reset_n)
      (reset_evt && !reset_detect_edge_mode)
         |-> $past(line_is_se0, 29))
      else $error("reset taken on a short se0 period");

   edge_reset_a: assert property ( // RL5
      @(posedge clk) disable iff (!reset_n)
      (reset_detect_edge_mode && line_prev == URC_LINE_J
       && line_is_se0) |=> (bus_flags[1] && bus_flags[4]))
      else $error("edge mode missed reset or runaway flag");

   idle_eop_a: assert property ( // RL2
      @(posedge clk) disable iff (!reset_n)
      (eop_evt && !receiver_on) |=> bus_flags[0])
      else $error("eop not seen while receiver halted");

   flag_hold_a: assert property ( // RL10
      @(posedge clk) disable iff (!reset_n)
      (bus_flags[0] && !wr_status) |=> bus_flags[0])
      else $error("eop flag dropped without a software clear");

   no_sw_set_a: assert property ( // RL13
      @(posedge clk) disable iff (!reset_n)
      (wr_status && !bus_flags[4] && !runaway_set)
         |=> !bus_flags[4])
      else $error("software write set the runaway flag");

   runaway_stop_a: assert property ( // RL11
      @(posedge clk) disable iff (!reset_n)
      timer_expire |=> (usb_clk_stop && bus_flags[4])
                       ##1 !usb_clk_stop)
      else $error("runaway timer did not stop clock and flag");

   resume_flags_a: assert property ( // RL14
      @(posedge clk) disable iff (!reset_n)
      resume_evt |=> (bus_flags[3] && bus_flags[4]))
      else $error("resume did not set resume and runaway flags");

   rx_off_a: assert property ( // RL19
      @(posedge clk) disable iff (!reset_n)
      (!receiver_on && !pkt_flags[0] && token_pid_hit)
         |=> !pkt_flags[0])
      else $error("packet flag set while receiver halted");

   pkt_clear_a: assert property ( // RL9
      @(posedge clk) disable iff (!reset_n)
      (packet_eop && !(receiver_on && token_pid_hit))
         |=> !pkt_flags[0])
      else $error("token flag survived eop");

endmodule

/* File: common/urc_pkg.sv */
// constants shared by the usb receive control and status logic
// assumes a 10 MHz system clock and an 8-bit cpu memory bus
package urc_pkg;

   // ======================================================
   // register addresses on the cpu memory bus
   localparam logic [15:0] URC_RX_MODE_ADDR   = 16'hff66;
   localparam logic [15:0] URC_RX_STATUS_ADDR = 16'hff67;
   localparam logic [15:0] URC_RX_ENABLE_ADDR = 16'hff6d;

   // ======================================================
   // reset values and implemented bits
   localparam logic [7:0] URC_REG_RESET   = 8'h00;
   localparam logic [7:0] URC_ENABLE_BITS = 8'h01;
   localparam logic [7:0] URC_MODE_BITS   = 8'h07;
   localparam logic [7:0] URC_MASK_LIMIT  = 8'h11;

   // ======================================================
   // field positions
   localparam int URC_RXON_BIT      = 0;
   localparam int URC_WMASK_BIT     = 0;
   localparam int URC_SYNC_IRQ_BIT  = 1;
   localparam int URC_EDGE_MODE_BIT = 2;

   // status byte: packet flags low, sticky bus flags high
   localparam int URC_TOKEN_BIT   = 0;
   localparam int URC_DATA_BIT    = 1;
   localparam int URC_HS_BIT      = 2;
   localparam int URC_EOP_BIT     = 3;
   localparam int URC_RESET_BIT   = 4;
   localparam int URC_SE0_BIT     = 5;
   localparam int URC_RESUME_BIT  = 6;
   localparam int URC_RUNAWAY_BIT = 7;
   localparam int URC_PKT_FLAGS   = 3;
   localparam int URC_BUS_FLAGS   = 5;

   // ======================================================
   // timing
   localparam int URC_CLK_PERIOD_NS = 100;
   localparam int URC_RESET_MIN_NS  = 3000;
   localparam int URC_RUNAWAY_NS    = 85300;
   localparam logic [5:0] URC_RESET_MIN_CYC = 6'((URC_RESET_MIN_NS
      + URC_CLK_PERIOD_NS - 1) / URC_CLK_PERIOD_NS);
   localparam logic [9:0] URC_RUNAWAY_CYC = 10'((URC_RUNAWAY_NS
      + URC_CLK_PERIOD_NS - 1) / URC_CLK_PERIOD_NS);

   // ======================================================
   // line state seen by the single-ended receiver
   typedef enum logic [3:0] {
      URC_LINE_J   = 4'h1,
      URC_LINE_K   = 4'h2,
      URC_LINE_SE0 = 4'h4,
      URC_LINE_SE1 = 4'h8
   } urc_line_type;

endpackage

/* File: src/urc_sticky.sv */
// sticky flag group: hardware sets, a clear request drops the bit
// assumes set and clear come from logic on the same clock
`timescale 1ns/100ps
module urc_sticky #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] set,
   input  wire logic [WIDTH-1:0] clear,
   output logic      [WIDTH-1:0] flag
);

   // a set in the same cycle as its clear wins so no event is lost
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag <= '0;
      end else begin
         flag <= set | (flag & ~clear);
      end
   end

endmodule

/* File: verification/urc_host_model.sv */
// host side of the usb pair: drives j, k and se0 onto the bus lines
// assumes the bench calls line() from its own clocked sequence
`timescale 1ns/100ps
module urc_host_model (
   input  wire logic clk,
   output logic      usb_dp,
   output logic      usb_dm
);
   // ==========================================================
   // bus idles in j; the host always drives, so no floating level
   initial begin
      usb_dp = 1'b1;
      usb_dm = 1'b0;
   end

   // ==========================================================
   // hold one line state for n clock cycles
   task automatic line(input logic dp, input logic dm, input int n);
      @(posedge clk);
      usb_dp <= dp;
      usb_dm <= dm;
      repeat (n) @(posedge clk);
   endtask
endmodule

/* File: verification/tb_usb_receive_control_status.sv */
// testbench for the usb receive control and status registers
// assumes a 10 MHz clock; host model drives the bus pair
`timescale 1ns/100ps
module tb_usb_receive_control_status;
   import urc_pkg::*;
   logic        clk, reset_n, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd;
   logic        usb_clk_running, usb_dp, usb_dm;
   logic [15:0] cpu_addr;
   logic [7:0]  cpu_wdata, cpu_rdata, buf_wr_addr, rv;
   logic [2:0]  cpu_bit_sel;
   logic [6:0]  ev;
   logic        buf_wr_allow, receiver_on, rx_buffer_write_mask;
   logic        sync_status_irq_enable, reset_detect_edge_mode;
   logic        sync_status_irq, usb_clk_stop;
   logic        clear_tx_reservations, clear_data_nak_enable;
   int          err_count, checked, n;

   urc_host_model host (.clk(clk), .usb_dp(usb_dp), .usb_dm(usb_dm));

   urc_rx_ctl dut (
      .clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr),
      .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_bit_wr(cpu_bit_wr),
      .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val),
      .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .usb_dp(usb_dp),
      .usb_dm(usb_dm), .token_pid_hit(ev[0]), .data_pid_hit(ev[1]),
      .handshake_pid_hit(ev[2]), .packet_eop(ev[3]),
      .setup_token_seen(ev[4]), .setup_reception(ev[5]),
      .usb_clk_running(usb_clk_running),
      .data_handshake_rx_irq(ev[6]), .buf_wr_addr(buf_wr_addr),
      .buf_wr_allow(buf_wr_allow), .receiver_on(receiver_on),
      .rx_buffer_write_mask(rx_buffer_write_mask),
      .sync_status_irq_enable(sync_status_irq_enable),
      .reset_detect_edge_mode(reset_detect_edge_mode),
      .sync_status_irq(sync_status_irq), .usb_clk_stop(usb_clk_stop),
      .clear_tx_reservations(clear_tx_reservations),
      .clear_data_nak_enable(clear_data_nak_enable));

   // ==========================================================
   // bus and compare tasks
   task automatic chk(input string nm, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      cpu_wr <= 1'b1;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge clk);
      cpu_wr <= 1'b0;
   endtask

   task automatic bwr(input logic [15:0] a, input logic [2:0] s,
                      input logic v);
      @(posedge clk);
      cpu_bit_wr <= 1'b1;
      cpu_addr <= a;
      cpu_bit_sel <= s;
      cpu_bit_val <= v;
      @(posedge clk);
      cpu_bit_wr <= 1'b0;
   endtask

   // read data stands for the cycle after the taking edge
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      cpu_rd <= 1'b1;
      cpu_addr <= a;
      @(posedge clk);
      cpu_rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), e, cpu_rdata);
   endtask

   // one-cycle event pulse; registered answers are settled on return
   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      #1;
   endtask

   task automatic irq(input logic e);
      @(posedge clk);
      ev[6] <= 1'b1;
      @(posedge clk);
      #1 chk("sync irq", {7'h0, e}, {7'h0, sync_status_irq});
      ev[6] <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs;
      rdc(URC_RX_ENABLE_ADDR, 8'h00);
      rdc(URC_RX_MODE_ADDR, 8'h00);
      rdc(URC_RX_STATUS_ADDR, 8'h00);
      rdc(16'hff68, 8'h00);
      wr(URC_RX_ENABLE_ADDR, 8'hff);
      rdc(URC_RX_ENABLE_ADDR, 8'h01);
      chk("receiver_on", 8'h01, {7'h0, receiver_on});
      bwr(URC_RX_ENABLE_ADDR, 3'h0, 1'b0);
      rdc(URC_RX_ENABLE_ADDR, 8'h00);
      bwr(URC_RX_STATUS_ADDR, 3'h7, 1'b1);
      rdc(URC_RX_STATUS_ADDR, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_mode;
      // edge mode stays off here: the bus is idle, not suspended
      wr(URC_RX_MODE_ADDR, 8'hfb);
      rdc(URC_RX_MODE_ADDR, 8'h03);
      buf_wr_addr <= 8'h12;
      #200 chk("allow 12", 8'h00, {7'h0, buf_wr_allow});
      buf_wr_addr <= URC_MASK_LIMIT;
      #200 chk("allow 11", 8'h01, {7'h0, buf_wr_allow});
      irq(1'b1);
      bwr(URC_RX_MODE_ADDR, 3'h1, 1'b0);
      irq(1'b0);
      bwr(URC_RX_MODE_ADDR, 3'h1, 1'b1);
      pulse(4);
      chk("clr tx", 8'h01, {7'h0, clear_tx_reservations});
      chk("clr nak", 8'h01, {7'h0, clear_data_nak_enable});
      rdc(URC_RX_MODE_ADDR, 8'h02);
      pulse(5);
      rdc(URC_RX_MODE_ADDR, 8'h00);
      $display("test mode done");
   endtask

   task automatic t_pkt;
      pulse(0);
      rdc(URC_RX_STATUS_ADDR, 8'h00);
      wr(URC_RX_ENABLE_ADDR, 8'h01);
      pulse(0);
      pulse(1);
      pulse(2);
      rdc(URC_RX_STATUS_ADDR, 8'h07);
      wr(URC_RX_STATUS_ADDR, 8'h00);
      rdc(URC_RX_STATUS_ADDR, 8'h07);
      pulse(3);
      rdc(URC_RX_STATUS_ADDR, 8'h00);
      $display("test packet done");
   endtask

   // receiver is off here: bus detection must carry on regardless
   task automatic t_bus;
      wr(URC_RX_ENABLE_ADDR, 8'h00);
      host.line(1'b0, 1'b0, 20);
      host.line(1'b1, 1'b0, 6);
      rdc(URC_RX_STATUS_ADDR, 8'h28);
      wr(URC_RX_STATUS_ADDR, 8'h00);
      rdc(URC_RX_STATUS_ADDR, 8'h00);
      host.line(1'b0, 1'b0, 40);
      host.line(1'b1, 1'b0, 6);
      rdc(URC_RX_STATUS_ADDR, 8'hb8);
      wr(URC_RX_STATUS_ADDR, 8'hff);
      rdc(URC_RX_STATUS_ADDR, 8'hb8);
      wr(URC_RX_STATUS_ADDR, 8'h00);
      host.line(1'b0, 1'b1, 8);
      host.line(1'b0, 1'b0, 2);
      host.line(1'b1, 1'b0, 6);
      rdc(URC_RX_STATUS_ADDR, 8'he8);
      wr(URC_RX_STATUS_ADDR, 8'h00);
      $display("test bus done");
   endtask

   // the quiet j line stands in for suspend while edge mode is set
   task automatic t_edge;
      wr(URC_RX_MODE_ADDR, 8'h04);
      rdc(URC_RX_MODE_ADDR, 8'h04);
      chk("edge mode", 8'h01, {7'h0, reset_detect_edge_mode});
      host.line(1'b0, 1'b0, 3);
      host.line(1'b1, 1'b0, 6);
      rdc(URC_RX_STATUS_ADDR, 8'hb8);
      rdc(URC_RX_STATUS_ADDR, 8'hb8);
      wr(URC_RX_MODE_ADDR, 8'h00);
      wr(URC_RX_STATUS_ADDR, 8'h00);
      $display("test edge done");
   endtask

   task automatic t_run;
      @(posedge clk);
      usb_clk_running <= 1'b1;
      for (n = 1; n <= 900; n++) begin
         @(posedge clk);
         #1;
         if (usb_clk_stop === 1'b1)
            break;
      end
      if (n > 900) begin
         $display("[ERR] usb_clk_stop expected 1 seen 0");
         err_count++;
         report_and_stop();
      end
      chk("stop cycle", 8'h01, {7'h0, n >= 852 && n <= 855});
      usb_clk_running <= 1'b0;
      rdc(URC_RX_STATUS_ADDR, 8'h80);
      wr(URC_RX_STATUS_ADDR, 8'h00);
      rdc(URC_RX_STATUS_ADDR, 8'h00);
      $display("test runaway done");
   endtask

   // ==========================================================
   // clock, reset and main sequence
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      err_count = 0;
      checked = 0;
      reset_n = 1'b0;
      {cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd} = 4'h0;
      usb_clk_running = 1'b0;
      cpu_addr = 16'h0000;
      cpu_wdata = 8'h00;
      cpu_bit_sel = 3'h0;
      buf_wr_addr = 8'h00;
      ev = 7'h00;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs();
      t_mode();
      t_pkt();
      t_bus();
      t_edge();
      t_run();
      report_and_stop();
   end
endmodule
